// ==== hw/adc_ctrl_pkg.sv ====
package adc_ctrl_pkg;
	// Printed register locations and the word index used on the bus
	localparam logic [31:0] CTRL_OFS  = 32'h50001500;
	localparam logic [31:0] CTRL2_OFS = 32'h50001502;
	localparam logic [31:0] CLR_OFS   = 32'h50001508;
	localparam logic [31:0] RES_OFS   = 32'h5000150A;
	localparam logic [31:0] DLY2_OFS  = 32'h5000150E;
	localparam logic [2:0]  IDX_CTRL  = 3'((CTRL_OFS - CTRL_OFS) >> 1);
	localparam logic [2:0]  IDX_CTRL2 = 3'((CTRL2_OFS - CTRL_OFS) >> 1);
	localparam logic [2:0]  IDX_CLR   = 3'((CLR_OFS - CTRL_OFS) >> 1);
	localparam logic [2:0]  IDX_RES   = 3'((RES_OFS - CTRL_OFS) >> 1);
	localparam logic [2:0]  IDX_DLY2  = 3'((DLY2_OFS - CTRL_OFS) >> 1);

	// Control register bit positions
	localparam int B_ZERO  = 15;
	localparam int B_LDO   = 14;
	localparam int B_CHOP  = 13;
	localparam int B_MUTE  = 12;
	localparam int B_SE    = 11;
	localparam int B_SIGN  = 10;
	localparam int B_SELHI = 9;
	localparam int B_SELLO = 6;
	localparam int B_MINT  = 5;
	localparam int B_INT   = 4;
	localparam int B_CLK   = 3;
	localparam int B_START = 1;
	localparam int B_EN    = 0;
	// Second control register bit positions
	localparam int B_I20U  = 3;
	localparam int B_IDYN  = 2;
	localparam int B_ATTN  = 1;
	localparam int B_DELAY = 0;

	// Writable masks and reset values
	localparam logic [15:0] CTRL_WMASK  = 16'hFFE9;
	localparam logic [15:0] CTRL2_WMASK = 16'h000F;
	localparam logic [15:0] DLY2_WMASK  = 16'hFFFF;
	localparam logic [15:0] CTRL_RST    = 16'h0000;
	localparam logic [3:0]  CTRL2_RST   = 4'h0;
	localparam logic [15:0] DLY2_RST    = 16'h8880;
	localparam logic [3:0]  SEL_LAST    = 4'h9;
	localparam logic [3:0]  SEL_PAIR0   = 4'h0;
	localparam logic [3:0]  SEL_PAIR1   = 4'h1;

	// One step of the enable delay setting, in ns, and in clock cycles
	localparam int TICK_NS  = 125;
	localparam int CLK_NS   = 8;
	localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int TICK_W   = $clog2(TICK_CYC + 1);

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_REQ  = 2'h1,
		ST_REL  = 2'h3,
		ST_FIN  = 2'h2
	} conv_state_e;
endpackage

// ==== hw/adc_control_registers.sv ====
// Overview of operation
// RULE_01 - Bit 15 forces regulator output to zero; bit 14 turns regulator on.
// RULE_02 - Chopping takes two samples of opposite polarity to cancel offset.
// RULE_03 - Bit 12 makes the converter sample at mid-scale.
// RULE_04 - Bit 11 picks differential (0) or single-ended (1) conversion.
// RULE_05 - Bit 10 inverts sign at converter input and output.
// RULE_06 - Single-ended selector 0-3 picks port pins, 4-9 supply nodes.
// RULE_07 - Differential selector 0 gives pins 0/1, anything else pins 2/3.
// RULE_08 - Software sets the input selector before writing the start bit.
// RULE_09 - Bit 5 masks (0) or passes (1) the done interrupt.
// RULE_10 - Read-only bit 4 rises when a conversion completes.
// RULE_11 - Done flag stays until software writes the clear register.
// RULE_12 - Bit 3 picks internal fast clock (0) or system clock (1).
// RULE_13 - Writing 1 to bit 1 starts a conversion; reading 0 means ready.
// RULE_14 - At the end the start bit clears and the done flag sets together.
// RULE_15 - Bit 0 low keeps the converter disabled and held in reset.
// RULE_16 - Second register bit 3 adds a constant regulator load.
// RULE_17 - Second register bit 2 enables a dynamic regulator load.
// RULE_18 - Second register bit 1 enables the threefold input attenuator.
// RULE_19 - Second register bit 0 enables delayed sequencing; hardware never clears it.
// RULE_20 - Software toggles the delay enable before every sampling.
// RULE_21 - Any write to the clear register clears the flag; reads give zero.
// RULE_22 - Result register holds the last 10-bit conversion value.
// RULE_23 - With delay on, converter enable trails regulator enable by setting.
// RULE_24 - Reserved bits and the test bit read zero and ignore writes.
// RULE_25 - Interrupt output is the done flag ANDed with the mask bit.
`timescale 1ns/1ps
module adc_control_registers #(
	parameter int RES_W = 10
) (
	input  wire logic              clk,                    // System clock
	input  wire logic              rst_b,                  // Sync reset
	input  wire logic [2:0]        address,                // Word index
	input  wire logic              read,                   // Read request
	input  wire logic              write,                  // Write request
	input  wire logic [31:0]       writedata,              // Write data
	input  wire logic [3:0]        byteenable,             // Byte lanes
	output logic      [31:0]       readdata,               // Read data
	output logic                   waitrequest,            // Bus stall
	input  wire logic              core_done,              // Core done level
	input  wire logic [RES_W-1:0]  core_data,              // Core sample
	output logic                   core_start,             // Sample request
	output logic                   regulator_force_zero,   // Regulator 0 V
	output logic                   regulator_on,           // Regulator on
	output logic                   offset_chopping,        // Chop mode
	output logic                   midscale_sample,        // Mid-scale
	output logic                   single_ended_select,    // Input mode
	output logic                   polarity_invert,        // Sign now
	output logic      [3:0]        route_code,             // Mux route
	output logic                   route_valid,            // Route legal
	output logic                   converter_clock_source, // Clock pick
	output logic                   converter_enable,       // Core enable
	output logic                   converter_reset_b,      // Core reset
	output logic                   constant_load_enable,   // Fixed load
	output logic                   dynamic_load_enable,    // Dynamic load
	output logic                   triple_attenuator_enable, // Attenuator
	output logic                   delay_function_enable,  // Delay mode
	output logic                   irq                     // Done interrupt
);

	// Refuse result widths the register layout cannot hold
	if (RES_W < 1 || RES_W > 16) begin : g_chk
		$error("RES_W must be 1 to 16");
	end

	typedef struct packed {
		logic [15:0]                ctrl;
		logic [3:0]                 ctrl2;
		logic [15:0]                dly;
		logic [RES_W-1:0]           result;
		adc_ctrl_pkg::conv_state_e  st;
		logic                       pass;
		logic [RES_W-1:0]           first;
		logic [7:0]                 dcnt;
		logic [adc_ctrl_pkg::TICK_W-1:0] tcnt;
		logic                       en_out;
		logic                       start_out;
		logic                       wait_r;
		logic [31:0]                rdata;
		logic                       irq;
		logic [1:0]                 done_s;
		logic [2*RES_W-1:0]         data_s;
		logic [3:0]                 route;
		logic                       route_ok;
		logic                       pol;
	} state_s;

	state_s          s_r;
	state_s          s_nxt;
	logic            wr_ok;
	logic            rd_take;
	logic            clr_hit;
	logic            sw_start;
	logic [RES_W-1:0] sample;
	logic [3:0]      sel;
	logic [RES_W:0]  sum;

	// Byte-lane merge of a write into a register
	function automatic logic [15:0] merge16(input logic [15:0] o,
		input logic [15:0] w, input logic [15:0] m, input logic [1:0] be);
		logic [15:0] k;
		k = {{8{be[1]}}, {8{be[0]}}} & m;
		return (o & ~k) | (w & k);
	endfunction

	// Bus handshake terms and synchronised core sample
	assign wr_ok    = write & ~s_r.wait_r;
	assign rd_take  = read & s_r.wait_r;
	assign clr_hit  = wr_ok && (address == adc_ctrl_pkg::IDX_CLR);
	assign sw_start = wr_ok && (address == adc_ctrl_pkg::IDX_CTRL)
		&& byteenable[0] && writedata[adc_ctrl_pkg::B_START];
	assign sample   = s_r.data_s[2*RES_W-1:RES_W];
	assign sum      = {1'b0, s_r.first} + {1'b0, sample};

	// Next state of the whole block
	always_comb begin
		s_nxt = s_r;
		sel = s_r.ctrl[adc_ctrl_pkg::B_SELHI:adc_ctrl_pkg::B_SELLO];
		s_nxt.done_s = {s_r.done_s[0], core_done};
		s_nxt.data_s = {s_r.data_s[RES_W-1:0], core_data};
		s_nxt.wait_r = ~((read | write) & s_r.wait_r);

		// Register writes; reserved and read-only bits keep their value
		if (wr_ok && address == adc_ctrl_pkg::IDX_CTRL) begin
			s_nxt.ctrl = merge16(s_r.ctrl, writedata[15:0],
				adc_ctrl_pkg::CTRL_WMASK, byteenable[1:0]); // RULE_24
		end
		if (sw_start) begin
			s_nxt.ctrl[adc_ctrl_pkg::B_START] = 1'b1; // RULE_13
		end
		if (wr_ok && address == adc_ctrl_pkg::IDX_CTRL2) begin
			s_nxt.ctrl2 = 4'(merge16({12'h000, s_r.ctrl2}, writedata[15:0],
				adc_ctrl_pkg::CTRL2_WMASK, byteenable[1:0])); // RULE_19
		end
		if (wr_ok && address == adc_ctrl_pkg::IDX_DLY2) begin
			s_nxt.dly = merge16(s_r.dly, writedata[15:0],
				adc_ctrl_pkg::DLY2_WMASK, byteenable[1:0]);
		end
		if (clr_hit) begin
			s_nxt.ctrl[adc_ctrl_pkg::B_INT] = 1'b0; // RULE_11
		end

		// Enable delay counter runs while the regulator is on
		if (!s_r.ctrl[adc_ctrl_pkg::B_LDO]) begin
			s_nxt.dcnt = 8'h00;
			s_nxt.tcnt = '0;
		end else if (s_r.dcnt != 8'hFF) begin
			if (s_r.tcnt == adc_ctrl_pkg::TICK_W'(adc_ctrl_pkg::TICK_CYC - 1))
			begin
				s_nxt.tcnt = '0;
				s_nxt.dcnt = s_r.dcnt + 8'h01;
			end else begin
				s_nxt.tcnt = s_r.tcnt + adc_ctrl_pkg::TICK_W'(1);
			end
		end
		if (s_r.ctrl2[adc_ctrl_pkg::B_DELAY]) begin
			s_nxt.en_out = s_r.ctrl[adc_ctrl_pkg::B_EN]
				&& s_r.ctrl[adc_ctrl_pkg::B_LDO]
				&& (s_r.dcnt >= s_r.dly[7:0]); // RULE_23
		end else begin
			s_nxt.en_out = s_r.ctrl[adc_ctrl_pkg::B_EN]; // RULE_15
		end

		// Conversion sequence; chopping runs two passes
		case (s_r.st)
			adc_ctrl_pkg::ST_IDLE: begin
				s_nxt.pass = 1'b0;
				if (s_r.ctrl[adc_ctrl_pkg::B_START] && s_r.en_out) begin
					s_nxt.st = adc_ctrl_pkg::ST_REQ; // RULE_13
				end
			end
			adc_ctrl_pkg::ST_REQ: begin
				s_nxt.start_out = 1'b1;
				if (s_r.done_s[1]) begin
					s_nxt.start_out = 1'b0;
					s_nxt.st = adc_ctrl_pkg::ST_REL;
					if (!s_r.pass) begin
						s_nxt.first = sample;
						if (!s_r.ctrl[adc_ctrl_pkg::B_CHOP]) begin
							s_nxt.result = sample; // RULE_22
						end
					end else begin
						s_nxt.result = sum[RES_W:1]; // RULE_02
					end
				end
			end
			adc_ctrl_pkg::ST_REL: begin
				if (!s_r.done_s[1]) begin
					if (s_r.ctrl[adc_ctrl_pkg::B_CHOP] && !s_r.pass) begin
						s_nxt.pass = 1'b1; // RULE_02
						s_nxt.st = adc_ctrl_pkg::ST_REQ;
					end else begin
						s_nxt.st = adc_ctrl_pkg::ST_FIN;
					end
				end
			end
			adc_ctrl_pkg::ST_FIN: begin
				s_nxt.ctrl[adc_ctrl_pkg::B_START] = sw_start; // RULE_14
				s_nxt.ctrl[adc_ctrl_pkg::B_INT] = 1'b1; // RULE_10
				s_nxt.st = adc_ctrl_pkg::ST_IDLE;
			end
			default: begin
				s_nxt.st = adc_ctrl_pkg::ST_IDLE;
			end
		endcase

		// Disabled converter drops any conversion in progress
		if (!s_nxt.ctrl[adc_ctrl_pkg::B_EN]) begin
			s_nxt.st = adc_ctrl_pkg::ST_IDLE; // RULE_15
			s_nxt.start_out = 1'b0;
			s_nxt.pass = 1'b0;
			s_nxt.ctrl[adc_ctrl_pkg::B_START] = 1'b0;
		end

		// Input routing towards the multiplexer
		if (s_r.ctrl[adc_ctrl_pkg::B_SE]) begin
			s_nxt.route = sel; // RULE_06
			s_nxt.route_ok = (sel <= adc_ctrl_pkg::SEL_LAST);
		end else begin
			s_nxt.route = (sel == adc_ctrl_pkg::SEL_PAIR0) ?
				adc_ctrl_pkg::SEL_PAIR0 : adc_ctrl_pkg::SEL_PAIR1; // RULE_07
			s_nxt.route_ok = 1'b1;
		end

		// Sign for the current pass and the gated interrupt
		s_nxt.pol = s_nxt.ctrl[adc_ctrl_pkg::B_SIGN]
			^ (s_nxt.ctrl[adc_ctrl_pkg::B_CHOP] & s_nxt.pass); // RULE_05
		s_nxt.irq = s_nxt.ctrl[adc_ctrl_pkg::B_INT]
			& s_nxt.ctrl[adc_ctrl_pkg::B_MINT]; // RULE_09 RULE_25

		// Read data is loaded on the same edge that drops waitrequest
		if (rd_take) begin
			case (address)
				adc_ctrl_pkg::IDX_CTRL:  s_nxt.rdata = {16'h0000, s_r.ctrl};
				adc_ctrl_pkg::IDX_CTRL2: s_nxt.rdata = {28'h0000000, s_r.ctrl2};
				adc_ctrl_pkg::IDX_RES:
					s_nxt.rdata = 32'({s_r.result}); // RULE_22
				adc_ctrl_pkg::IDX_DLY2:  s_nxt.rdata = {16'h0000, s_r.dly};
				default:                 s_nxt.rdata = 32'h00000000; // RULE_21
			endcase
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_r <= '0;
			s_r.ctrl <= adc_ctrl_pkg::CTRL_RST;
			s_r.ctrl2 <= adc_ctrl_pkg::CTRL2_RST;
			s_r.dly <= adc_ctrl_pkg::DLY2_RST;
			s_r.st <= adc_ctrl_pkg::ST_IDLE;
			s_r.wait_r <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign readdata                 = s_r.rdata;
	assign waitrequest              = s_r.wait_r;
	assign core_start               = s_r.start_out;
	assign regulator_force_zero     = s_r.ctrl[adc_ctrl_pkg::B_ZERO]; // RULE_01
	assign regulator_on             = s_r.ctrl[adc_ctrl_pkg::B_LDO]; // RULE_01
	assign offset_chopping          = s_r.ctrl[adc_ctrl_pkg::B_CHOP];
	assign midscale_sample          = s_r.ctrl[adc_ctrl_pkg::B_MUTE]; // RULE_03
	assign single_ended_select      = s_r.ctrl[adc_ctrl_pkg::B_SE]; // RULE_04
	assign polarity_invert          = s_r.pol;
	assign route_code               = s_r.route;
	assign route_valid              = s_r.route_ok;
	assign converter_clock_source   = s_r.ctrl[adc_ctrl_pkg::B_CLK]; // RULE_12
	assign converter_enable         = s_r.en_out;
	assign converter_reset_b        = s_r.en_out; // RULE_15
	assign constant_load_enable     = s_r.ctrl2[adc_ctrl_pkg::B_I20U]; // RULE_16
	assign dynamic_load_enable      = s_r.ctrl2[adc_ctrl_pkg::B_IDYN]; // RULE_17
	assign triple_attenuator_enable = s_r.ctrl2[adc_ctrl_pkg::B_ATTN]; // RULE_18
	assign delay_function_enable    = s_r.ctrl2[adc_ctrl_pkg::B_DELAY];
	assign irq                      = s_r.irq;

	// Checks
	irq_gate_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_25
		irq == (s_r.ctrl[adc_ctrl_pkg::B_INT] & s_r.ctrl[adc_ctrl_pkg::B_MINT]))
		else $error("irq differs from flag and mask");
	done_update_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_14
		s_r.st == adc_ctrl_pkg::ST_FIN && !sw_start |=>
		s_r.ctrl[adc_ctrl_pkg::B_INT] && !s_r.ctrl[adc_ctrl_pkg::B_START])
		else $error("finish did not clear start and set flag");
	flag_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		clr_hit && s_r.st != adc_ctrl_pkg::ST_FIN |=>
		!s_r.ctrl[adc_ctrl_pkg::B_INT])
		else $error("clear write left flag set");
	clr_reads_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
		read && !waitrequest && $past(address) == adc_ctrl_pkg::IDX_CLR
		|-> readdata == 32'h00000000) // RULE_21
		else $error("clear register read not zero");
	disable_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		!s_r.ctrl[adc_ctrl_pkg::B_EN] |=> !converter_reset_b && !core_start)
		else $error("disabled converter not held in reset"); // RULE_15
	delay_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(regulator_on) && delay_function_enable && s_r.dly[7:0] != 8'h00
		|=> !converter_enable [*2]) // RULE_23
		else $error("enable came before delay");
	// Route is judged against the selector that produced it, a cycle back
	route_diff_a: assert property (@(posedge clk) disable iff (!rst_b)
		!single_ended_select && $stable(s_r.ctrl) |=> route_code ==
		(($past(s_r.ctrl[adc_ctrl_pkg::B_SELHI:adc_ctrl_pkg::B_SELLO])
		== adc_ctrl_pkg::SEL_PAIR0) ?
		adc_ctrl_pkg::SEL_PAIR0 : adc_ctrl_pkg::SEL_PAIR1)) // RULE_07
		else $error("differential route wrong");
	route_se_a: assert property (@(posedge clk) disable iff (!rst_b)
		single_ended_select && $stable(s_r.ctrl) |=>
		route_code
		== $past(s_r.ctrl[adc_ctrl_pkg::B_SELHI:adc_ctrl_pkg::B_SELLO])
		&& route_valid
		== ($past(s_r.ctrl[adc_ctrl_pkg::B_SELHI:adc_ctrl_pkg::B_SELLO])
		<= adc_ctrl_pkg::SEL_LAST)) // RULE_06
		else $error("single-ended route wrong");
	// Reserved bits of the second register never show on the bus
	reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
		read && !waitrequest
		&& $past(address) == adc_ctrl_pkg::IDX_CTRL2
		|-> readdata[31:4] == 28'h0000000
		&& s_r.ctrl[2] == 1'b0) // RULE_24
		else $error("reserved bit set");
	polarity_now_a: assert property (@(posedge clk) disable iff (!rst_b)
		polarity_invert == (s_r.ctrl[adc_ctrl_pkg::B_SIGN]
		^ (s_r.ctrl[adc_ctrl_pkg::B_CHOP] & s_r.pass))) // RULE_05
		else $error("polarity output wrong");
endmodule

// ==== bench/adc_core_model.sv ====
`timescale 1ns/1ps
module adc_core_model (
	input  wire logic       clk,     // System clock
	input  wire logic       start,   // Sample request
	input  wire logic       pol,     // Polarity now
	input  wire logic       reset_b, // Core reset
	input  wire logic       slow,    // Long sample time
	input  wire logic [9:0] val_a,   // Normal sample
	input  wire logic [9:0] val_b,   // Inverted sample
	output logic            done,    // Done level
	output logic      [9:0] data     // Sample value
);
	int cnt;

	initial begin
		done = 1'b0;
		data = 10'h000;
		cnt = 0;
	end

	// Answer a request; after release the data lines turn over
	always @(posedge clk) begin
		if (!reset_b) begin
			done <= 1'b0;
			cnt <= 0;
		end else if (start && !done) begin
			cnt <= cnt + 1;
			if (cnt >= (slow ? 40 : 3)) begin
				done <= 1'b1;
				data <= pol ? val_b : val_a;
				cnt <= 0;
			end
		end else if (!start && done) begin
			done <= 1'b0;
			data <= ~data;
		end
	end
endmodule

// ==== bench/adc_control_registers_tb.sv ====
`timescale 1ns/1ps
module adc_control_registers_tb;
	localparam logic [2:0] A_CTL = adc_ctrl_pkg::IDX_CTRL;
	localparam logic [2:0] A_CT2 = adc_ctrl_pkg::IDX_CTRL2;
	logic clk, rst_b, read, write, waitrequest, core_done, core_start, irq;
	logic [2:0] address;
	logic [31:0] writedata, readdata;
	logic [3:0] byteenable, route_code;
	logic [9:0] core_data, val_a, val_b;
	logic fz, ro, ch, ms, se, pi, rv, cs, ce, crb, cl, dl, ta, df, slow;
	logic [15:0] q;
	int n_mismatch, checks;

	adc_control_registers dut (.clk, .rst_b, .address, .read, .write,
		.writedata, .byteenable, .readdata, .waitrequest, .core_done,
		.core_data, .core_start, .regulator_force_zero(fz),
		.regulator_on(ro), .offset_chopping(ch), .midscale_sample(ms),
		.single_ended_select(se), .polarity_invert(pi), .route_code,
		.route_valid(rv), .converter_clock_source(cs),
		.converter_enable(ce), .converter_reset_b(crb),
		.constant_load_enable(cl), .dynamic_load_enable(dl),
		.triple_attenuator_enable(ta), .delay_function_enable(df), .irq);
	adc_core_model core (.clk, .start(core_start), .pol(pi), .reset_b(crb),
		.slow, .val_a, .val_b, .done(core_done), .data(core_data));

	// Free running clock
	always #4 clk = ~clk;

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [2:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		writedata <= {16'h0000, d};
		write <= w;
		read <= ~w;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50) chk("bus_answer", 32'h0, 32'h1);
		q = readdata[15:0];
		write <= 1'b0;
		read <= 1'b0;
	endtask

	task automatic rc(input logic [2:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000);
		chk("read", {16'h0000, e}, {16'h0000, q});
	endtask

	// Run one conversion and check flag, interrupt, result and clear
	task automatic conv(input logic [15:0] cfg, input logic [9:0] r,
		input logic ie);
		int n;
		bus(1'b1, A_CTL, cfg | 16'h0001);
		bus(1'b1, A_CTL, cfg | 16'h0003);
		n = 0;
		do begin
			bus(1'b0, A_CTL, 16'h0000);
			n++;
		end while (q[1] !== 1'b0 && n < 60);
		rc(A_CTL, cfg | 16'h0011);
		chk("irq", ie, irq);
		rc(adc_ctrl_pkg::IDX_RES, {6'h00, r});
		bus(1'b1, adc_ctrl_pkg::IDX_CLR, 16'h5A3C);
		rc(A_CTL, cfg | 16'h0001);
		chk("irq_clr", 1'b0, irq);
	endtask

	// Watchdog
	initial begin
		#(8 * 40000);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		{read, write, slow} = 3'b000;
		address = 3'h0;
		writedata = 32'h0;
		byteenable = 4'h3;
		val_a = 10'h2A5;
		val_b = 10'h011;
		repeat (10) @(posedge clk);
		chk("wait_rst", 1'b1, waitrequest);
		rst_b <= 1'b1;
		rc(A_CTL, 16'h0000);
		rc(A_CT2, 16'h0000);
		rc(adc_ctrl_pkg::IDX_CLR, 16'h0000);
		rc(adc_ctrl_pkg::IDX_RES, 16'h0000);
		rc(adc_ctrl_pkg::IDX_DLY2, 16'h8880);
		rc(3'h2, 16'h0000);
		bus(1'b1, A_CTL, 16'hFFFC);
		rc(A_CTL, 16'hFFE8);
		repeat (2) @(posedge clk);
		chk("ctl_pins", 7'h7F, {fz, ro, ch, ms, se, pi, cs});
		bus(1'b1, A_CTL, 16'h0000);
		repeat (2) @(posedge clk);
		chk("ctl_pins", 7'h00, {fz, ro, ch, ms, se, pi, cs});
		bus(1'b1, A_CT2, 16'hFFFF);
		rc(A_CT2, 16'h000F);
		repeat (2) @(posedge clk);
		chk("ct2_pins", 4'hF, {cl, dl, ta, df});
		bus(1'b1, A_CT2, 16'h0000);
		for (int m = 0; m < 32; m++) begin
			bus(1'b1, A_CTL, {4'h0, m[4], 1'b0, m[3:0], 6'h00});
			repeat (2) @(posedge clk);
			chk("route", m[4] ? {m[3:0] <= 4'h9, m[3:0]}
				: {1'b1, 3'h0, m[3:0] != 4'h0}, {rv, route_code});
		end
		bus(1'b1, A_CTL, 16'h0001);
		repeat (2) @(posedge clk);
		chk("enable", 2'b11, {ce, crb});
		conv(16'h0020, 10'h2A5, 1'b1);
		conv(16'h0000, 10'h2A5, 1'b0);
		conv(16'h0420, 10'h011, 1'b1);
		val_a <= 10'h100;
		val_b <= 10'h2FF;
		conv(16'h2020, 10'h1FF, 1'b1);
		slow <= 1'b1;
		bus(1'b1, A_CTL, 16'h0003);
		repeat (5) @(posedge clk);
		bus(1'b1, A_CTL, 16'h0000);
		rc(A_CTL, 16'h0000);
		chk("core_reset", 2'b00, {ce, crb});
		slow <= 1'b0;
		bus(1'b1, A_CT2, 16'h0001);
		bus(1'b1, A_CTL, 16'h4001);
		repeat (1900) @(posedge clk);
		chk("delay_early", 1'b0, ce);
		repeat (400) @(posedge clk);
		chk("delay_late", 1'b1, ce);
		rc(A_CT2, 16'h0001);
		give_verdict();
	end
endmodule
